// [ctimer.sv]
`timescale 1ns/1ns
module ctimer
   import ctimer_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // port lines
   input  wire logic        PORT3_LINE_ONE,
   output logic             PORT3_LINE_SIX,
   // interrupts
   output logic             FIRST_TIMER_IRQ,
   output logic             SECOND_TIMER_IRQ,
   output logic             IRQ
);

   typedef struct packed {
      logic [1:0][7:0] pre_reg;
      logic [1:0][7:0] load;
      logic [1:0][7:0] count;
      logic [1:0][5:0] pre_cnt;
      logic [1:0]      run;
      logic [1:0]      modulo;
      logic [7:0]      mode;
      logic [1:0]      irq_stat;
      logic [1:0]      irq_mask;
      logic [1:0]      div4;
      logic            ext_prev;
      logic            armed;
      logic [1:0]      tog;
      logic [31:0]     rdata;
   } state_s;

   state_s r;
   state_s next_r;

   logic       wr;
   logic       rd;
   logic       hit;
   logic [1:0] pre_tick;
   logic [1:0] eoc;
   logic [1:0] src_tick;
   logic       int_div_tick;
   logic       ext_rise;
   logic       clk_half;
   ext_fn_e    ext_fn;
   out_sel_e   out_sel;

   assign wr      = PSEL & PENABLE & PWRITE;
   // read captured at the setup edge so data stands through the access
   assign rd      = PSEL & ~PENABLE & ~PWRITE;
   assign PREADY  = 1'b1;
   assign ext_fn  = ext_fn_e'(r.mode[MODE_EXT_LSB +: 2]);
   assign out_sel = out_sel_e'(r.mode[MODE_OUT_LSB +: 2]);
   assign ext_rise = PORT3_LINE_ONE & ~r.ext_prev;
   assign int_div_tick = (r.div4 == 2'(INT_DIV - 1));
   assign clk_half = r.div4[1];

   always_comb begin
      hit = 1'b1;
      if (PADDR == OFS_FIRST_PRESCALE) begin
      end else if (PADDR == OFS_FIRST_LOAD) begin
      end else if (PADDR == OFS_FIRST_COUNT) begin
      end else if (PADDR == SECOND_PRESCALE_ADDR) begin
      end else if (PADDR == OFS_SECOND_LOAD) begin
      end else if (PADDR == OFS_SECOND_COUNT) begin
      end else if (PADDR == OFS_CONTROL) begin
      end else if (PADDR == OFS_MODE) begin
      end else if (PADDR == OFS_IRQ_STATUS) begin
      end else if (PADDR == OFS_IRQ_MASK) begin
      end else begin
         hit = 1'b0;
      end
   end
   assign PSLVERR = PSEL & PENABLE & ~hit;

   // clock source ahead of each prescaler
   always_comb begin
      src_tick[0] = 1'b1;
      src_tick[1] = int_div_tick;
      if (r.mode[MODE_CASCADE]) begin
         src_tick[1] = eoc[0];
      end else if (r.pre_reg[1][PRE_EXT_BIT]) begin
         case (ext_fn)
            EXT_CLOCK:   src_tick[1] = ext_rise;
            EXT_GATE:    src_tick[1] = int_div_tick & PORT3_LINE_ONE;
            EXT_TRIGGER: src_tick[1] = int_div_tick & r.armed;
            default:     src_tick[1] = 1'b0;
         endcase
      end
   end

   // one shared tick path per timer; eoc stays comb from current state
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_tmr
         // zero ratio field means divide by 64, as 6-bit wrap
         assign pre_tick[g] = r.run[g] & src_tick[g] & (r.pre_cnt[g] == 6'd1);
         assign eoc[g] = pre_tick[g] & (r.count[g] == 8'd1);
      end
   endgenerate

   always_comb begin
      next_r = r;
      next_r.ext_prev = PORT3_LINE_ONE;
      next_r.div4 = r.div4 + 2'd1;
      next_r.rdata = 32'h0000_0000;
      for (int i = 0; i < 2; i++) begin
         if (r.run[i] & src_tick[i]) begin
            next_r.pre_cnt[i] = r.pre_cnt[i] - 6'd1;
            if (pre_tick[i]) begin
               next_r.pre_cnt[i] = r.pre_reg[i][7:PRE_RATIO_LSB];
               next_r.count[i] = r.count[i] - 8'd1;
               if (eoc[i]) begin
                  next_r.count[i] = r.load[i];
                  if (!r.modulo[i]) begin
                     next_r.count[i] = 8'h00;
                     next_r.run[i] = 1'b0;
                  end
               end
            end
         end
      end
      // non-modulo second timer disarms at end of count; an edge arms it when disarmed or in retrigger mode
      if (eoc[1] & ~r.modulo[1]) begin
         next_r.armed = 1'b0;
      end
      if (ext_rise & (r.mode[MODE_RETRIG] | ~r.armed)) begin
         next_r.armed = 1'b1;
         if (ext_fn == EXT_TRIGGER && r.mode[MODE_RETRIG]) begin
            next_r.count[1] = r.load[1];
            next_r.pre_cnt[1] = r.pre_reg[1][7:PRE_RATIO_LSB];
         end
      end
      // write-one clear; a fresh event in the same cycle wins
      if (wr && PADDR == OFS_IRQ_STATUS) begin
         next_r.irq_stat = r.irq_stat & ~PWDATA[1:0];
      end
      next_r.irq_stat = next_r.irq_stat | eoc;
      if (wr) begin
         if (PADDR == OFS_FIRST_PRESCALE) begin
            next_r.pre_reg[0] = PWDATA[7:0];
         end else if (PADDR == SECOND_PRESCALE_ADDR) begin
            next_r.pre_reg[1] = PWDATA[7:0];
         end else if (PADDR == OFS_FIRST_LOAD) begin
            next_r.load[0] = PWDATA[7:0];
         end else if (PADDR == OFS_SECOND_LOAD) begin
            next_r.load[1] = PWDATA[7:0];
         end else if (PADDR == OFS_MODE) begin
            next_r.mode = PWDATA[7:0];
         end else if (PADDR == OFS_IRQ_MASK) begin
            next_r.irq_mask = PWDATA[1:0];
         end else if (PADDR == OFS_CONTROL) begin
            for (int i = 0; i < 2; i++) begin
               next_r.modulo[i] = PWDATA[i*CTL_STRIDE + CTL_MODULO];
               // second timer starts only when its mode bit is zero
               next_r.run[i] = PWDATA[i*CTL_STRIDE + CTL_RUN] &
                  ((i == 0) | ~r.pre_reg[1][PRE_MODE_BIT]);
               if (PWDATA[i*CTL_STRIDE + CTL_LOAD]) begin
                  next_r.count[i] = r.load[i];
                  next_r.pre_cnt[i] = r.pre_reg[i][7:PRE_RATIO_LSB];
               end
            end
         end
      end
      if (eoc[0]) begin
         next_r.tog[0] = ~r.tog[0];
      end
      if (eoc[1]) begin
         next_r.tog[1] = ~r.tog[1];
      end
      if (rd) begin
         if (PADDR == OFS_FIRST_COUNT) begin
            next_r.rdata = {24'h00_0000, r.count[0]};
         end else if (PADDR == OFS_SECOND_COUNT) begin
            next_r.rdata = {24'h00_0000, r.count[1]};
         end else if (PADDR == OFS_FIRST_LOAD) begin
            next_r.rdata = {24'h00_0000, r.load[0]};
         end else if (PADDR == OFS_SECOND_LOAD) begin
            next_r.rdata = {24'h00_0000, r.load[1]};
         end else if (PADDR == OFS_CONTROL) begin
            next_r.rdata = {25'h000_0000, r.modulo[1], 1'b0, r.run[1],
                            1'b0, r.modulo[0], 1'b0, r.run[0]};
         end else if (PADDR == OFS_MODE) begin
            next_r.rdata = {24'h00_0000, r.mode};
         end else if (PADDR == OFS_IRQ_STATUS) begin
            next_r.rdata = {30'h0000_0000, r.irq_stat};
         end else if (PADDR == OFS_IRQ_MASK) begin
            next_r.rdata = {30'h0000_0000, r.irq_mask};
         end
      end
   end

   // read data registered in setup, so zero-wait access returns it
   always_comb begin
      PRDATA = r.rdata;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   always_comb begin
      case (out_sel)
         OUT_FIRST:  PORT3_LINE_SIX = r.tog[0];
         OUT_SECOND: PORT3_LINE_SIX = r.tog[1];
         OUT_CLOCK:  PORT3_LINE_SIX = clk_half;
         default:    PORT3_LINE_SIX = 1'b0;
      endcase
   end

   assign FIRST_TIMER_IRQ  = r.irq_stat[0] & r.irq_mask[0];
   assign SECOND_TIMER_IRQ = r.irq_stat[1] & r.irq_mask[1];
   assign IRQ = FIRST_TIMER_IRQ | SECOND_TIMER_IRQ;

endmodule : ctimer

// [ctimer_ext.sv]
`timescale 1ns/1ns
module ctimer_ext (
   // sequencing
   input  wire logic       CLK,
   input  wire logic       start,
   input  wire logic [7:0] pulses,
   input  wire logic       gate,
   // timer input line
   output logic            line
);
   logic [8:0] left = 9'h0;
   // one-cycle pulses, low between them and at rest
   always_ff @(posedge CLK) left <= start ? {pulses, 1'b0} : left - {8'h0, left != 9'h0};
   assign line = gate | left[0];
endmodule : ctimer_ext

// [ctimer_pkg.sv]
package ctimer_pkg;
   // register byte offsets
   localparam logic [11:0] OFS_FIRST_PRESCALE  = 12'h0_000;
   localparam logic [11:0] OFS_FIRST_LOAD      = 12'h0_004;
   localparam logic [11:0] OFS_FIRST_COUNT     = 12'h0_008;
   localparam logic [11:0] OFS_SECOND_PRESCALE = 12'h0_0F3;
   localparam logic [11:0] OFS_SECOND_LOAD     = 12'h0_010;
   localparam logic [11:0] OFS_SECOND_COUNT    = 12'h0_014;
   localparam logic [11:0] OFS_CONTROL         = 12'h0_018;
   localparam logic [11:0] OFS_MODE            = 12'h0_01C;
   localparam logic [11:0] OFS_IRQ_STATUS      = 12'h0_020;
   localparam logic [11:0] OFS_IRQ_MASK        = 12'h0_024;
   // printed offset 0xf3 is not word aligned: kept as an index
   localparam logic [11:0] SECOND_PRESCALE_ADDR = {OFS_SECOND_PRESCALE[9:0], 2'b00};
   // prescale register fields (ratio in bits 7:2)
   localparam int PRE_RATIO_LSB   = 2;
   localparam int PRE_MODE_BIT    = 1;
   localparam int PRE_EXT_BIT     = 0;
   // control register fields, per timer n at bit 4*n
   localparam int CTL_RUN     = 0;
   localparam int CTL_LOAD    = 1;
   localparam int CTL_MODULO  = 2;
   localparam int CTL_STRIDE  = 4;
   // mode register fields
   localparam int MODE_EXT_LSB  = 0;
   localparam int MODE_RETRIG   = 2;
   localparam int MODE_CASCADE  = 3;
   localparam int MODE_OUT_LSB  = 4;
   localparam int INT_DIV       = 4;
   localparam logic [7:0] PRE_RESET = 8'h00;

   typedef enum logic [1:0] {EXT_CLOCK, EXT_TRIGGER, EXT_GATE, EXT_OFF} ext_fn_e;
   typedef enum logic [1:0] {OUT_FIRST, OUT_SECOND, OUT_CLOCK, OUT_LOW} out_sel_e;
endpackage : ctimer_pkg

// [ctimer_sva.sv]
`timescale 1ns/1ns
module ctimer_sva
   import ctimer_pkg::*;
(
   // clock and reset
   input wire logic        CLK,
   input wire logic        RST,
   // apb
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // pins
   input wire logic        PORT3_LINE_ONE,
   input wire logic        PORT3_LINE_SIX,
   input wire logic        FIRST_TIMER_IRQ,
   input wire logic        SECOND_TIMER_IRQ,
   input wire logic        IRQ
);
   default clocking dc @(posedge CLK); endclocking
   default disable iff (RST);
   wire acc = PSEL && PENABLE;
   ready_high_a: assert property (PREADY) else $error("pready low");
   err_phase_a: assert property (PSLVERR |-> acc) else $error("error outside access");
   bad_addr_a: assert property (acc && PADDR == 12'hFFC |-> PSLVERR) else $error("no error");
   good_addr_a: assert property (acc && PADDR == OFS_CONTROL |-> !PSLVERR)
      else $error("error on mapped");
   read_width_a: assert property (PRDATA[31:8] == 24'h0) else $error("upper bits");
   read_idle_a: assert property (!$past(PSEL && !PENABLE && !PWRITE) |-> PRDATA == 32'h0)
      else $error("read data stands");
   irq_or_a: assert property (IRQ == (FIRST_TIMER_IRQ || SECOND_TIMER_IRQ))
      else $error("irq not or");
   irq_sticky_a: assert property ($fell(IRQ) |-> $past(acc && PWRITE))
      else $error("irq fell alone");
   mask_off_a: assert property (acc && PWRITE && PADDR == OFS_IRQ_MASK
      && PWDATA[1:0] == 2'b00 |-> ##[1:2] !IRQ) else $error("masked irq");
   first_c: cover property ($rose(FIRST_TIMER_IRQ));
   second_c: cover property ($rose(SECOND_TIMER_IRQ));
   err_c: cover property (PSLVERR);
endmodule : ctimer_sva

// [ctimer_tb.sv]
`timescale 1ns/1ns
module testbench;
   import ctimer_pkg::*;
   logic        CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h0;
   logic [31:0] PWDATA = 32'h0, PRDATA, rv;
   logic        PREADY, PSLVERR, PORT3_LINE_SIX, FIRST_TIMER_IRQ, SECOND_TIMER_IRQ, IRQ;
   logic        line, err, go = 1'b0, gate = 1'b0;
   logic [7:0]  k = 8'h0;
   int          fails = 0, tests_run = 0, cyc = 0, p, n, t;
   ctimer ctimer_inst (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .PORT3_LINE_ONE(line), .PORT3_LINE_SIX(PORT3_LINE_SIX), .FIRST_TIMER_IRQ(FIRST_TIMER_IRQ),
      .SECOND_TIMER_IRQ(SECOND_TIMER_IRQ), .IRQ(IRQ));
   ctimer_ext ctimer_ext_inst (.CLK(CLK), .start(go), .pulses(k), .gate(gate), .line(line));
   initial forever #25 CLK = ~CLK;
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails = fails + 1;
         results();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      err = PSLVERR;
      rv = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic wirq;
      t = 0;
      while (IRQ !== 1'b1 && t < 20000) begin
         @(posedge CLK);
         t++;
      end
   endtask : wirq
   task automatic send(input logic [7:0] m);
      k <= m;
      go <= 1'b1;
      @(posedge CLK);
      go <= 1'b0;
      repeat (2 * m + 4) @(posedge CLK);
   endtask : send
   function automatic int ticks(int pr, int ld);
      return (pr == 0 ? 64 : pr) * (ld == 0 ? 256 : ld);
   endfunction : ticks
   initial begin
      void'($urandom(35));
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      rd(OFS_CONTROL);
      chk("control reset", rv, 32'h0);
      rd(12'hFFC);
      chk("unmapped", {31'h0, err}, 32'h1);
      wr(OFS_IRQ_MASK, 32'h3);
      for (int i = 0; i < 4; i++) begin
         p = (i == 0) ? 0 : $urandom_range(8, 1);
         n = (i == 1) ? 0 : $urandom_range(6, 1);
         wr(OFS_FIRST_PRESCALE, 32'(p << PRE_RATIO_LSB));
         wr(OFS_FIRST_LOAD, 32'(n));
         wr(OFS_CONTROL, 32'h3);
         wirq();
         chk("period", 32'(t > ticks(p, n) - 4 && t < ticks(p, n) + 3), 32'h1);
         rd(OFS_FIRST_COUNT);
         chk("single stop", rv, 32'h0);
         rd(OFS_IRQ_STATUS);
         chk("status", rv, 32'h1);
         wr(OFS_IRQ_STATUS, 32'h1);
         chk("cleared", {31'h0, IRQ}, 32'h0);
      end
      wr(OFS_FIRST_PRESCALE, 32'h8);
      wr(OFS_FIRST_LOAD, 32'h5);
      wr(OFS_CONTROL, 32'h7);
      wirq();
      wr(OFS_IRQ_STATUS, 32'h1);
      wirq();
      chk("modulo", 32'(t > 2 && t < 10), 32'h1);
      wr(OFS_CONTROL, 32'h4);
      rd(OFS_FIRST_COUNT);
      n = rv;
      repeat (30) @(posedge CLK);
      rd(OFS_FIRST_COUNT);
      chk("held", rv, 32'(n));
      wr(OFS_IRQ_STATUS, 32'h1);
      wr(OFS_CONTROL, 32'h5);
      wirq();
      chk("continue", 32'(t > 2 * n - 5 && t < 2 * n + 2), 32'h1);
      wr(OFS_CONTROL, 32'h0);
      wr(OFS_IRQ_MASK, 32'h2);
      wr(OFS_IRQ_STATUS, 32'h3);
      wr(OFS_CONTROL, 32'h3);
      repeat (20) @(posedge CLK);
      chk("masked", {31'h0, IRQ}, 32'h0);
      wr(OFS_IRQ_MASK, 32'h3);
      chk("unmasked", {31'h0, FIRST_TIMER_IRQ}, 32'h1);
      wr(OFS_MODE, 32'h0);
      wr(SECOND_PRESCALE_ADDR, 32'h7);
      wr(OFS_SECOND_LOAD, 32'h14);
      wr(OFS_CONTROL, 32'h30);
      rd(OFS_SECOND_COUNT);
      n = rv;
      send(8'h5);
      rd(OFS_SECOND_COUNT);
      chk("mode off", rv, 32'(n));
      wr(SECOND_PRESCALE_ADDR, 32'h5);
      wr(OFS_CONTROL, 32'h30);
      n = $urandom_range(12, 1);
      send(8'(n));
      rd(OFS_SECOND_COUNT);
      chk("ext edges", rv, 32'(20 - n));
      wr(OFS_MODE, 32'h2);
      wr(SECOND_PRESCALE_ADDR, 32'h5);
      wr(OFS_CONTROL, 32'h30);
      repeat (40) @(posedge CLK);
      rd(OFS_SECOND_COUNT);
      chk("gate shut", rv, 32'h14);
      gate <= 1'b1;
      repeat (40) @(posedge CLK);
      gate <= 1'b0;
      rd(OFS_SECOND_COUNT);
      chk("gate open", 32'(rv > 7 && rv < 13), 32'h1);
      wr(OFS_MODE, 32'h5);
      send(8'h1);
      wr(OFS_MODE, 32'h20);
      t = 0;
      err = PORT3_LINE_SIX;
      repeat (8) begin
         @(posedge CLK);
         t += (PORT3_LINE_SIX !== err);
         err = PORT3_LINE_SIX;
      end
      chk("clock out", 32'(t), 32'h4);
      wr(OFS_MODE, 32'h30);
      chk("out low", {31'h0, PORT3_LINE_SIX}, 32'h0);
      wr(OFS_FIRST_PRESCALE, 32'h4);
      wr(OFS_FIRST_LOAD, 32'h2);
      wr(OFS_MODE, 32'h8);
      wr(SECOND_PRESCALE_ADDR, 32'h4);
      wr(OFS_CONTROL, 32'h37);
      repeat (20) @(posedge CLK);
      rd(OFS_SECOND_COUNT);
      chk("cascade", 32'(rv > 4 && rv < 14), 32'h1);
      results();
   end
endmodule : testbench
bind ctimer ctimer_sva ctimer_sva_inst (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .PORT3_LINE_ONE(PORT3_LINE_ONE), .PORT3_LINE_SIX(PORT3_LINE_SIX),
   .FIRST_TIMER_IRQ(FIRST_TIMER_IRQ), .SECOND_TIMER_IRQ(SECOND_TIMER_IRQ), .IRQ(IRQ));
